// >>> verilog/meas_framer.sv
// Measurement word framer with APB registers and serial output
//
// The register addresses and the APB interface to the registers were decided locally.
`include "framer_defs.svh"
module meas_framer
  import framer_pkg::*;
#(
  parameter int SLOTS = `MAX_SLOTS
) (
  // Clock and reset
  input  wire logic                   clk_i,
  input  wire logic                   nrst_i,
  // APB slave
  input  wire logic                   psel_i,
  input  wire logic                   penable_i,
  input  wire logic                   pwrite_i,
  input  wire logic [11:0]            paddr_i,
  input  wire logic [31:0]            pwdata_i,
  output logic [31:0]                 prdata_o,
  output logic                        pready_o,
  output logic                        pslverr_o,
  // Measurement sample
  input  wire logic                   sample_valid_i,
  input  wire logic [`WORD_W-1:0]     distance_i,
  input  wire logic                   dist_error_i,
  input  wire framer_pkg::err_code_type err_code_i,
  input  wire logic                   no_peak_i,
  input  wire logic                   before_range_i,
  input  wire logic                   after_range_i,
  input  wire logic                   triggered_i,
  input  wire logic [1:0]             lamp_colour_i,
  input  wire logic [`WORD_W-1:0]     aux_value_i [SLOTS],
  // Serial output and interrupt
  output logic                        txd_o,
  output logic                        irq_o
);
  import framer_pkg::*;

  localparam int SW = `SLOT_IDX_W;

  typedef struct packed {
    frame_state_type            st;
    logic                       enable;
    logic [`DIV_W-1:0]          divisor;
    logic [SW:0]                count;
    logic [SW-1:0]              pos;
    logic [SLOTS-1:0][SW-1:0]   order;
    logic [SLOTS*`WORD_W-1:0]   snap;
    logic [`WORD_W-1:0]         word;
    logic                       last;
    logic                       overload;
    logic [`IRQ_W-1:0]          irq_stat;
    logic [`IRQ_W-1:0]          irq_mask;
    logic [31:0]                rdata;
    logic                       ready;
  } fr_state_type;
  fr_state_type s_q, s_d;

  logic             tx_ready;
  logic             tx_valid;
  logic [7:0]       tx_data;
  logic [`WORD_W-1:0] status_word;
  logic [`WORD_W-1:0] dist_word;
  logic [SLOTS*`WORD_W-1:0] live;
  logic             apb_access;
  logic             apb_wr;
  logic             apb_rd;
  logic [`IRQ_W-1:0] ev;
  logic             drop;

  // Status word assembly
  always_comb begin
    status_word = '0;
    status_word[`ST_NO_PEAK] = no_peak_i;
    status_word[`ST_BEFORE]  = before_range_i;
    status_word[`ST_AFTER]   = after_range_i;
    status_word[`ST_TRIG]    = triggered_i;
    status_word[`ST_LED_LO +: 2] = lamp_colour_i;
  end

  // Distance with reserved error codes substituted
  always_comb begin
    dist_word = distance_i;
    if (dist_error_i) begin
      unique case (err_code_i)
        ERRC_NO_PEAK:   dist_word = `CODE_NO_PEAK;
        ERRC_BEFORE:    dist_word = `CODE_BEFORE;
        ERRC_AFTER:     dist_word = `CODE_AFTER;
        ERRC_NOT_EVAL:  dist_word = `CODE_NOT_EVAL;
        ERRC_TOO_WIDE:  dist_word = `CODE_TOO_WIDE;
        ERRC_LASER_OFF: dist_word = `CODE_LASER_OFF;
        default:        dist_word = `CODE_NOT_EVAL;
      endcase
    end
    if (s_q.overload) begin
      dist_word = `CODE_OVERLOAD;
    end
  end

  // Per-slot live values; slot 0 distance, slot 1 status
  always_comb begin
    for (int i = 0; i < SLOTS; i++) begin
      live[i*`WORD_W +: `WORD_W] = aux_value_i[i];
    end
    live[0 +: `WORD_W]       = dist_word;
    live[`WORD_W +: `WORD_W] = status_word;
  end

  assign apb_access = psel_i && penable_i;
  assign apb_wr     = apb_access && pwrite_i;
  assign apb_rd     = apb_access && !pwrite_i;

  // Sample arriving while a block is still being sent
  assign drop = sample_valid_i && s_q.enable && (s_q.st != FR_IDLE);
  always_comb begin
    ev = '0;
    ev[`IRQ_DROPPED] = drop;
  end

  always_comb begin
    logic [SW-1:0] slot;
    slot = '0;
    s_d = s_q;
    s_d.ready = 1'b0;
    slot = s_q.order[s_q.pos];
    tx_valid = 1'b0;
    tx_data  = '0;

    unique case (s_q.st)
      FR_IDLE: begin
        if (sample_valid_i && s_q.enable) begin
          s_d.snap = live;
          s_d.pos  = '0;
          s_d.st   = FR_LOAD;
        end
      end
      FR_LOAD: begin
        s_d.word = s_q.snap[slot*`WORD_W +: `WORD_W];
        s_d.last = ({1'b0, s_q.pos} == s_q.count - 1'b1);
        s_d.st   = FR_LOW;
      end
      FR_LOW: begin
        tx_valid = 1'b1;
        tx_data  = {`TAG_LOW, s_q.word[0 +: `CHUNK_W]};
        if (tx_ready) s_d.st = FR_MID;
      end
      FR_MID: begin
        tx_valid = 1'b1;
        tx_data  = {`TAG_MID, s_q.word[`CHUNK_W +: `CHUNK_W]};
        if (tx_ready) s_d.st = FR_HIGH;
      end
      FR_HIGH: begin
        tx_valid = 1'b1;
        tx_data  = {(s_q.last ? `TAG_HIGH_LAST : `TAG_HIGH_MORE),
                    s_q.word[2*`CHUNK_W +: `CHUNK_W]};
        if (tx_ready) begin
          if (s_q.last) begin
            s_d.st = FR_IDLE;
            s_d.irq_stat[`IRQ_BLOCK_DONE] = 1'b1;
          end else begin
            s_d.pos = s_q.pos + 1'b1;
            s_d.st  = FR_LOAD;
          end
        end
      end
      default: s_d.st = FR_IDLE;
    endcase

    // Overload flag: sample lost because the rate cannot keep up
    if (drop) begin
      s_d.overload = 1'b1;
    end else if (s_q.st == FR_IDLE && sample_valid_i && s_q.enable) begin
      s_d.overload = 1'b0;
    end
    if (drop && !s_q.overload) s_d.irq_stat[`IRQ_OVERLOAD] = 1'b1;

    // APB register access; slave answers in the access phase cycle
    if (apb_access) s_d.ready = 1'b0;
    s_d.rdata = '0;
    if (psel_i && !penable_i && !pwrite_i) begin
      if (paddr_i == `ADDR_CTRL) s_d.rdata = {31'h0, s_q.enable};
      else if (paddr_i == `ADDR_DIVISOR) s_d.rdata = {16'h0, s_q.divisor};
      else if (paddr_i == `ADDR_SELECT) s_d.rdata = {27'h0, s_q.count};
      else if (paddr_i == `ADDR_IRQ_STATUS) s_d.rdata = {29'h0, s_q.irq_stat};
      else if (paddr_i == `ADDR_IRQ_MASK) s_d.rdata = {29'h0, s_q.irq_mask};
      else if (paddr_i == `ADDR_INFO) s_d.rdata = {14'h0, s_q.word};
      else if (paddr_i >= `ADDR_SLOT_BASE && paddr_i < `ADDR_SLOT_BASE + 12'(4*SLOTS))
        s_d.rdata = {28'h0, s_q.order[paddr_i[SW+1:2]]};
    end
    if (apb_rd && paddr_i == `ADDR_IRQ_STATUS) s_d.irq_stat = '0;
    if (apb_wr) begin
      if (paddr_i == `ADDR_CTRL) s_d.enable = pwdata_i[0];
      else if (paddr_i == `ADDR_DIVISOR && pwdata_i[`DIV_W-1:0] >= `DIV_MIN)
        s_d.divisor = pwdata_i[`DIV_W-1:0];
      else if (paddr_i == `ADDR_SELECT && s_q.st == FR_IDLE
               && pwdata_i[SW:0] != '0 && pwdata_i[SW:0] <= (SW+1)'(SLOTS))
        s_d.count = pwdata_i[SW:0];
      else if (paddr_i == `ADDR_IRQ_MASK) s_d.irq_mask = pwdata_i[`IRQ_W-1:0];
      else if (paddr_i >= `ADDR_SLOT_BASE && paddr_i < `ADDR_SLOT_BASE + 12'(4*SLOTS)
               && s_q.st == FR_IDLE)
        s_d.order[paddr_i[SW+1:2]] = pwdata_i[SW-1:0];
    end
    // Dropped-sample event set wins over read clear; block-done and overload sets lose to a same-cycle read clear
    s_d.irq_stat = s_d.irq_stat | ev;
  end

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      s_q          <= '0;
      s_q.st       <= FR_IDLE;
      s_q.enable   <= 1'b1;
      s_q.divisor  <= `DIV_DEFAULT;
      s_q.count    <= (SW+1)'(1);
      for (int i = 0; i < SLOTS; i++) s_q.order[i] <= SW'(i);
    end else begin
      s_q <= s_d;
    end
  end

  // Serial transmission takes its bit time from the divisor register of the register path
  uart_tx_8n1 u_tx (
    .clk_i     (clk_i),
    .nrst_i    (nrst_i),
    .divisor_i (s_q.divisor),
    .valid_i   (tx_valid),
    .data_i    (tx_data),
    .ready_o   (tx_ready),
    .txd_o     (txd_o)
  );

  assign prdata_o  = s_q.rdata;
  assign pready_o  = 1'b1;
  assign pslverr_o = 1'b0;
  assign irq_o     = |(s_q.irq_stat & s_q.irq_mask);
endmodule // meas_framer

// >>> verilog/framer_defs.svh
// Constants of the measurement framer
`ifndef FRAMER_DEFS_SVH
`define FRAMER_DEFS_SVH
`define CLK_HZ            125000000
`define BAUD_DEFAULT      921600
`define BAUD_MAX          4000000
`define DIV_W             16
`define DIV_DEFAULT       16'h0088
`define DIV_MIN           16'h001F
`define WORD_W            18
`define CHUNK_W           6
`define TAG_LOW           2'h0
`define TAG_MID           2'h1
`define TAG_HIGH_MORE     2'h3
`define TAG_HIGH_LAST     2'h2
`define CODE_OVERLOAD     18'h3FFBB
`define CODE_NO_PEAK      18'h3FFBC
`define CODE_BEFORE       18'h3FFBD
`define CODE_AFTER        18'h3FFBE
`define CODE_NOT_EVAL     18'h3FFC0
`define CODE_TOO_WIDE     18'h3FFC1
`define CODE_LASER_OFF    18'h3FFC2
`define ST_NO_PEAK        2
`define ST_BEFORE         5
`define ST_AFTER          6
`define ST_TRIG           15
`define ST_LED_LO         16
`define MAX_SLOTS         16
`define SLOT_IDX_W        4
`define SLOT_DISTANCE     4'h0
`define SLOT_STATUS       4'h1
`define ADDR_CTRL         12'h000
`define ADDR_DIVISOR      12'h004
`define ADDR_SELECT       12'h008
`define ADDR_IRQ_STATUS   12'h00C
`define ADDR_IRQ_MASK     12'h010
`define ADDR_INFO         12'h014
`define ADDR_SLOT_BASE    12'h040
`define IRQ_W             3
`define IRQ_BLOCK_DONE    0
`define IRQ_OVERLOAD      1
`define IRQ_DROPPED       2
`endif

// >>> verilog/framer_pkg.sv
// Types of the measurement framer
package framer_pkg;
  typedef enum logic [1:0] {
    ERR_NONE      = 2'h0,
    ERR_NO_PEAK   = 2'h1,
    ERR_OTHER     = 2'h2,
    ERR_RESERVED  = 2'h3
  } err_class_type;
  typedef enum logic [2:0] {
    FR_IDLE = 3'h0,
    FR_LOAD = 3'h1,
    FR_LOW  = 3'h3,
    FR_MID  = 3'h2,
    FR_HIGH = 3'h6
  } frame_state_type;
  typedef enum logic [2:0] {
    ERRC_NO_PEAK   = 3'h0,
    ERRC_BEFORE    = 3'h1,
    ERRC_AFTER     = 3'h2,
    ERRC_NOT_EVAL  = 3'h3,
    ERRC_TOO_WIDE  = 3'h4,
    ERRC_LASER_OFF = 3'h5
  } err_code_type;
endpackage

// >>> verilog/uart_tx_8n1.sv
// 8N1 serial character transmitter
`include "framer_defs.svh"
module uart_tx_8n1 (
  // Clock and reset
  input  wire logic              clk_i,
  input  wire logic              nrst_i,
  // Bit timing
  input  wire logic [`DIV_W-1:0] divisor_i,
  // Character in
  input  wire logic              valid_i,
  input  wire logic [7:0]        data_i,
  output logic                   ready_o,
  // Line
  output logic                   txd_o
);
  typedef struct packed {
    logic [`DIV_W-1:0] cnt;
    logic [3:0]        bitn;
    logic [9:0]        shreg;
    logic              busy;
    logic              line;
  } tx_state_type;
  tx_state_type s_q, s_d;

  always_comb begin
    s_d = s_q;
    if (!s_q.busy) begin
      if (valid_i) begin
        s_d.shreg = {1'b1, data_i, 1'b0};
        s_d.busy  = 1'b1;
        s_d.bitn  = 4'h0;
        s_d.cnt   = divisor_i;
        s_d.line  = 1'b0;
      end
    end else if (s_q.cnt == '0) begin
      if (s_q.bitn == 4'h9) begin
        s_d.busy = 1'b0;
        s_d.line = 1'b1;
      end else begin
        s_d.bitn  = s_q.bitn + 4'h1;
        s_d.shreg = {1'b1, s_q.shreg[9:1]};
        s_d.line  = s_q.shreg[1];
        s_d.cnt   = divisor_i;
      end
    end else begin
      s_d.cnt = s_q.cnt - `DIV_W'(1);
    end
  end

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      s_q <= '{cnt: '0, bitn: '0, shreg: 10'h3FF, busy: 1'b0, line: 1'b1};
    end else begin
      s_q <= s_d;
    end
  end

  assign ready_o = !s_q.busy;
  assign txd_o   = s_q.line;
endmodule // uart_tx_8n1

// >>> bench/meas_framer_checker.sv
// Port assertions of the measurement framer
module meas_framer_checker (
  input wire logic        clk_i,
  input wire logic        nrst_i,
  input wire logic        psel_i,
  input wire logic        penable_i,
  input wire logic        pwrite_i,
  input wire logic [11:0] paddr_i,
  input wire logic [31:0] prdata_o,
  input wire logic        pready_o,
  input wire logic        pslverr_o,
  input wire logic        txd_o,
  input wire logic        irq_o
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge clk_i); endclocking
  default disable iff (!nrst_i);
  logic rd_setup;
  assign rd_setup = psel_i && !penable_i && !pwrite_i;
  a_zero_wait: assert property (psel_i && penable_i |-> pready_o) else $error("no ready");
  a_no_slverr: assert property (!pslverr_o) else $error("slave error");
  a_start_low: assert property ($fell(txd_o) |=> !txd_o [*8]) else $error("short start bit");
  a_bit_time: assert property ($changed(txd_o) |=> $stable(txd_o) [*8]) else $error("bit too short");
  a_idle_high: assert property ($rose(nrst_i) |-> txd_o [*4]) else $error("line not idle");
  a_irq_reset: assert property ($rose(nrst_i) |-> !irq_o) else $error("irq after reset");
  a_unmapped_zero: assert property (rd_setup && paddr_i == 12'h100 |=> prdata_o == 32'h0) else $error("unmapped");
  a_div_floor: assert property (rd_setup && paddr_i == 12'h004 |=> prdata_o >= 32'h1F) else $error("div low");
  c_frame: cover property ($fell(txd_o));
  c_irq: cover property ($rose(irq_o));
  c_write: cover property (psel_i && penable_i && pwrite_i);
endmodule // meas_framer_checker

// >>> bench/serial_rx_model.sv
// Host receiver that deframes tagged measurement bytes
module serial_rx_model #(
  parameter int BITC = 32
) (
  input  wire logic clk_i,
  input  wire logic rxd_i,
  output int        bad_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [18:0] q [$];
  logic [7:0]  b;
  logic [17:0] w;
  int          st = 0;
  int          t;
  initial bad_o = 0;
  always begin
    @(negedge rxd_i);
    repeat (BITC / 2) @(posedge clk_i);
    if (rxd_i !== 1'b0) bad_o++;
    for (int i = 0; i < 9; i++) begin
      repeat (BITC) @(posedge clk_i);
      if (i < 8) b[i] = rxd_i;
    end
    if (rxd_i !== 1'b1) bad_o++;
    t = b[7] ? 2 : int'(b[6]);
    if (t != st) bad_o++;
    w[6*t +: 6] = b[5:0];
    st = (t == 2) ? 0 : t + 1;
    if (t == 2) q.push_back({~b[6], w});
  end
endmodule // serial_rx_model

// >>> bench/meas_framer_tb.sv
// Testbench of the measurement framer
module meas_framer_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import framer_pkg::*;
  logic         clk_i = 1'b0, nrst_i = 1'b0, psel_i = 1'b0, penable_i = 1'b0, pwrite_i = 1'b0;
  logic [11:0]  paddr_i = 12'h000;
  logic [31:0]  pwdata_i = 32'h0, prdata_o, rd;
  logic         pready_o, pslverr_o, txd_o, irq_o, sample_valid_i = 1'b0, dist_error_i = 1'b0;
  logic         no_peak_i = 1'b0, before_range_i = 1'b0, after_range_i = 1'b0, triggered_i = 1'b0;
  logic [1:0]   lamp_colour_i = 2'h0;
  logic [17:0]  distance_i = 18'h0, aux_value_i [16];
  logic [17:0]  codes [6] = '{18'h3FFBC, 18'h3FFBD, 18'h3FFBE, 18'h3FFC0, 18'h3FFC1, 18'h3FFC2};
  err_code_type err_code_i = ERRC_NO_PEAK;
  int           n_fail = 0, cmp_count = 0, rx_bad;
  meas_framer u_dut (.clk_i, .nrst_i, .psel_i, .penable_i, .pwrite_i, .paddr_i, .pwdata_i, .prdata_o, .pready_o,
    .pslverr_o, .sample_valid_i, .distance_i, .dist_error_i, .err_code_i, .no_peak_i, .before_range_i,
    .after_range_i, .triggered_i, .lamp_colour_i, .aux_value_i, .txd_o, .irq_o);
  serial_rx_model #(.BITC(32)) u_rx (.clk_i, .rxd_i(txd_o), .bad_o(rx_bad));
  initial begin
    forever #4 clk_i = ~clk_i;
  end
  task automatic complete_run();
    $display("compares %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    cmp_count++;
    if (g !== e) begin
      n_fail++;
      $display("BAD %0t got %h expected %h", $time, g, e);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int k;
    psel_i <= 1'b1;
    pwrite_i <= w;
    paddr_i <= a;
    pwdata_i <= d;
    @(posedge clk_i);
    penable_i <= 1'b1;
    k = 0;
    do begin
      @(posedge clk_i);
      k++;
    end while (pready_o !== 1'b1 && k < 50);
    if (k == 50) begin
      chk(32'h0, 32'h1);
      complete_run();
    end
    rd = prdata_o;
    psel_i <= 1'b0;
    penable_i <= 1'b0;
    @(posedge clk_i);
  endtask
  task automatic smp();
    sample_valid_i <= 1'b1;
    @(posedge clk_i);
    sample_valid_i <= 1'b0;
    @(posedge clk_i);
  endtask
  task automatic get(input logic [17:0] e, input logic l);
    logic [18:0] t;
    for (int k = 0; k < 2000 && u_rx.q.size() == 0; k++) apb(1'b0, 12'h000, 32'h0);
    if (u_rx.q.size() == 0) begin
      chk(32'h0, 32'h1);
      complete_run();
    end
    t = u_rx.q.pop_front();
    chk({13'h0, t}, {13'h0, l, e});
  endtask
  initial begin
    for (int i = 0; i < 16; i++) aux_value_i[i] = 18'h01000 + 18'(i);
    repeat (8) @(posedge clk_i);
    nrst_i <= 1'b1;
    @(posedge clk_i);
    apb(1'b0, 12'h004, 32'h0);
    chk(rd, 32'h88);
    apb(1'b1, 12'h004, 32'h1E);
    apb(1'b0, 12'h004, 32'h0);
    chk(rd, 32'h88);
    apb(1'b1, 12'h004, 32'h1F);
    apb(1'b0, 12'h004, 32'h0);
    chk(rd, 32'h1F);
    apb(1'b0, 12'h100, 32'h0);
    chk(rd, 32'h0);
    apb(1'b1, 12'h010, 32'h1);
    distance_i <= 18'h2A5C3;
    smp();
    get(18'h2A5C3, 1'b1);
    repeat (40) @(posedge clk_i);
    chk({31'h0, irq_o}, 32'h1);
    apb(1'b0, 12'h00C, 32'h0);
    chk({31'h0, rd[0]}, 32'h1);
    chk({31'h0, irq_o}, 32'h0);
    $display("test registers and single value done");
    dist_error_i <= 1'b1;
    for (int i = 0; i < 6; i++) begin
      err_code_i <= err_code_type'(i);
      smp();
      get(codes[i], 1'b1);
      repeat (20) @(posedge clk_i);
    end
    dist_error_i <= 1'b0;
    $display("test error codes done");
    apb(1'b1, 12'h008, 32'h3);
    for (int c = 0; c < 4; c++) begin
      lamp_colour_i <= 2'(c);
      no_peak_i <= c[0];
      before_range_i <= !c[0];
      after_range_i <= c[1];
      triggered_i <= c[1];
      smp();
      get(18'h2A5C3, 1'b0);
      get({c[1:0], c[1], 8'h0, c[1], !c[0], 2'h0, c[0], 2'h0}, 1'b0);
      get(18'h01002, 1'b1);
      repeat (20) @(posedge clk_i);
    end
    $display("test status block done");
    apb(1'b1, 12'h008, 32'h1);
    apb(1'b0, 12'h00C, 32'h0);
    apb(1'b1, 12'h010, 32'h7);
    smp();
    smp();
    get(18'h2A5C3, 1'b1);
    repeat (20) @(posedge clk_i);
    smp();
    get(18'h3FFBB, 1'b1);
    repeat (40) @(posedge clk_i);
    chk({31'h0, irq_o}, 32'h1);
    apb(1'b0, 12'h00C, 32'h0);
    chk({29'h0, rd[2:0]}, 32'h7);
    chk({31'h0, irq_o}, 32'h0);
    chk(32'(rx_bad), 32'h0);
    $display("test overload done");
    complete_run();
  end
endmodule // meas_framer_tb
bind meas_framer meas_framer_checker u_chk (.clk_i, .nrst_i, .psel_i, .penable_i, .pwrite_i, .paddr_i, .prdata_o,
  .pready_o, .pslverr_o, .txd_o, .irq_o);
